// ===== mpb_pkg.sv
/*
 * Shared constants, register map, field layouts and state codes for the
 * multiphase step-down converter control block.
 * Assumes a 125 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package mpb_pkg;

	// Register byte offsets (one aligned word each)
	localparam logic [7:0] OFF_MASTER_CTRL = 8'h00;
	localparam logic [7:0] OFF_SLAVE1_CTRL = 8'h04;
	localparam logic [7:0] OFF_SLAVE2_CTRL = 8'h08;
	localparam logic [7:0] OFF_SLAVE3_CTRL = 8'h0C;
	localparam logic [7:0] OFF_MASTER_DELAY = 8'h10;
	localparam logic [7:0] OFF_CONFIG = 8'h14;
	localparam logic [7:0] OFF_CLOCK = 8'h18;
	localparam logic [7:0] OFF_LOAD_SEL = 8'h1C;
	localparam logic [7:0] OFF_LOAD_LO = 8'h20;
	localparam logic [7:0] OFF_LOAD_HI = 8'h24;
	localparam logic [7:0] OFF_FLAGS = 8'h28;
	localparam logic [7:0] OFF_MASKS = 8'h2C;
	localparam logic [7:0] OFF_STATUS = 8'h30;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
	localparam int DISCHARGE_BIT = 4;

	// Load-current result: 10 bits, 20 mA per code, all ones = 20.46 A
	localparam int LOAD_W = 10;
	localparam int LOAD_LO_W = 8;
	localparam int LOAD_LSB_MA = 20;
	localparam int LOAD_FULL_MA = 20460;

	// Timing figures and their cycle counts at the system clock
	localparam int CLK_PERIOD_NS = 8;
	localparam int SYS_CLK_MHZ = 125;
	localparam int MEAS_TIME_NS = 50000;
	localparam int MEAS_CYCLES = MEAS_TIME_NS / CLK_PERIOD_NS;
	localparam int BOOT_TIME_NS = 1000000;
	localparam int BOOT_CYCLES = BOOT_TIME_NS / CLK_PERIOD_NS;
	localparam int STEP_HALF_NS = 320000;
	localparam int STEP_HALF_DBL_NS = 640000;
	localparam int STEP_NORM_NS = 1000000;
	localparam int STEP_DBL_NS = 2000000;
	localparam int STEP_HALF_CYC = STEP_HALF_NS / CLK_PERIOD_NS;
	localparam int STEP_HALF_DBL_CYC = STEP_HALF_DBL_NS / CLK_PERIOD_NS;
	localparam int STEP_NORM_CYC = STEP_NORM_NS / CLK_PERIOD_NS;
	localparam int STEP_DBL_CYC = STEP_DBL_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 22;

	// External clock detector: valid band is -30 %/+10 % of nominal
	localparam int DET_CNT_W = 8;
	localparam logic [DET_CNT_W-1:0] DET_CNT_MAX = 8'hFF;
	localparam logic [2:0] DET_GOOD_PERIODS = 3'h4;
	localparam logic [19:0] DET_LO_NUM = 20'h00007;
	localparam logic [19:0] DET_HI_NUM = 20'h0000B;
	localparam logic [19:0] DET_REF = 20'(SYS_CLK_MHZ * 10);
	localparam logic [4:0] FREQ_MAX_CODE = 5'h17;

	typedef enum logic [1:0] {
		CLK_RC = 2'b00,
		CLK_AUTO = 2'b01,
		CLK_ACTIVE_ONLY = 2'b10,
		CLK_RSVD = 2'b11
	} mpb_clkmode_t;

	typedef enum logic [1:0] {
		ST_BOOT = 2'b00,
		ST_STANDBY = 2'b01,
		ST_ACTIVE = 2'b10
	} mpb_state_t;

	typedef struct packed {
		logic discharge;
		logic [1:0] pinChoice;
		logic pinCtrl;
		logic regOn;
	} mpb_ctrl_t;

	typedef struct packed {
		logic [3:0] turnOff;
		logic [3:0] turnOn;
	} mpb_delay_t;

	typedef struct packed {
		logic dither;
		logic halfDelay;
		logic doubleDelay;
	} mpb_cfg_t;

	typedef struct packed {
		logic [4:0] syncFreq;
		mpb_clkmode_t mode;
	} mpb_clk_t;

	typedef struct packed {
		logic [3:0] curLimit;
		logic noSync;
		logic syncClk;
		logic loadReady;
	} mpb_flags_t;

	typedef struct packed {
		logic ditherActive;
		logic extSelected;
		logic extPresent;
		logic regulatorOut;
		mpb_state_t state;
	} mpb_status_t;

	localparam mpb_ctrl_t CTRL_RST = '0;
	localparam mpb_delay_t DELAY_RST = '0;
	localparam mpb_cfg_t CFG_RST = '0;
	localparam mpb_clk_t CLKCFG_RST = '0;
	localparam mpb_flags_t FLAGS_RST = '0;

endpackage : mpb_pkg

// ===== mpb_control.sv
/*
 * Digital control of a four-phase step-down converter: register file on
 * AHB-Lite, load-current measurement, clock source selection with external
 * clock detection, power-up order and regulator enable sequencing.
 * Assumes enable pins and the external sync clock are asynchronous, while
 * phase currents and current-limit pulses come from sys_clk logic.
 */
// Function
// - Core zero is master; its registers rule all.
// - Slave control ignored except discharge; limit flags kept.
// - Writing phase selection starts a measurement.
// - Measurement finishes within 50 us.
// - Finished measurement sets maskable ready flag.
// - Result low eight bits, high two bits.
// - Result is 20 mA per code.
// - Result is selected phase's own current.
// - Dither only with RC clock; all cores.
// - Five-bit nominal sync frequency, 1 to 24 MHz.
// - External clock valid within -30%/+10% band.
// - Clock mode selects detector and auto switching.
// - Sync clock appear/disappear raises maskable flag.
// - Missing clock flag at mode-specific transitions.
// - After boot enter STANDBY; enable from STANDBY/ACTIVE.
// - Register bit alone enables or disables output.
// - Register bit control acts immediately.
// - Pin choice selects one of three pins.
// - Pin edges enable/disable after programmed delays.
// - Delays apply only to pin transitions.
// - Delay step 0.32, 0.64, 1 or 2 ms.
// - Interrupt low while any unmasked flag pends.
`timescale 1ns/1ps
module mpb_control #(
	parameter int MEAS_CYC = mpb_pkg::MEAS_CYCLES,
	parameter int BOOT_CYC = mpb_pkg::BOOT_CYCLES,
	parameter int STEP_A_CYC = mpb_pkg::STEP_HALF_CYC,
	parameter int STEP_B_CYC = mpb_pkg::STEP_HALF_DBL_CYC,
	parameter int STEP_C_CYC = mpb_pkg::STEP_NORM_CYC,
	parameter int STEP_D_CYC = mpb_pkg::STEP_DBL_CYC
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic enablePinOne,
	input wire logic enablePinTwo,
	input wire logic enablePinThree,
	input wire logic externalSyncInput,
	input wire logic [3:0][mpb_pkg::LOAD_W-1:0] phaseCurrent,
	input wire logic [3:0] phaseCurrentLimit,
	output logic [3:0] phaseEnable,
	output logic [3:0] outputDischargeEnable,
	output logic useExternalClock,
	output logic detectorEnable,
	output logic ditherActive,
	output logic irqOutN
);
	import mpb_pkg::*;

	localparam logic [CNT_W-1:0] MEAS_LOAD = CNT_W'(MEAS_CYC - 1);
	localparam logic [CNT_W-1:0] BOOT_LOAD = CNT_W'(BOOT_CYC - 1);
	localparam logic [CNT_W-1:0] STEP_A = CNT_W'(STEP_A_CYC - 1);
	localparam logic [CNT_W-1:0] STEP_B = CNT_W'(STEP_B_CYC - 1);
	localparam logic [CNT_W-1:0] STEP_C = CNT_W'(STEP_C_CYC - 1);
	localparam logic [CNT_W-1:0] STEP_D = CNT_W'(STEP_D_CYC - 1);

	// Pin inputs: three flops, a level counts once stages two and three agree
	logic [3:0] rawIn;
	logic [3:0] pinLevel;
	logic [3:0] pinRise;
	logic [3:0] pinFall;

	assign rawIn = {externalSyncInput, enablePinThree, enablePinTwo,
		enablePinOne};

	for (genvar i = 0; i < 4; i++)
	begin : g_sync
		logic s1_r, s2_r, s3_r, filt_r, prev_r, filt_nxt;
		always_comb
		begin
			filt_nxt = (s2_r == s3_r) ? s3_r : filt_r;
		end
		always_ff @(posedge sys_clk or negedge rstn)
		begin
			if (!rstn)
			begin
				s1_r <= 1'b0;
				s2_r <= 1'b0;
				s3_r <= 1'b0;
				filt_r <= 1'b0;
				prev_r <= 1'b0;
			end
			else
			begin
				s1_r <= rawIn[i];
				s2_r <= s1_r;
				s3_r <= s2_r;
				filt_r <= filt_nxt;
				prev_r <= filt_r;
			end
		end
		assign pinLevel[i] = filt_r;
		assign pinRise[i] = filt_r & ~prev_r;
		assign pinFall[i] = ~filt_r & prev_r;
	end

	// Bus slave state
	logic wrPend_r, wrPend_nxt, rdWait_r, rdWait_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [31:0] hrdata_r, hrdata_nxt, readMux;
	logic addrTaken, wrStrobe;

	// Register file
	mpb_ctrl_t ctrl_r, ctrl_nxt;
	logic [2:0] slaveDis_r, slaveDis_nxt;
	mpb_delay_t delay_r, delay_nxt;
	mpb_cfg_t cfg_r, cfg_nxt;
	mpb_clk_t clkCfg_r, clkCfg_nxt;
	logic [1:0] loadSel_r, loadSel_nxt;
	mpb_flags_t flags_r, flags_nxt, masks_r, masks_nxt, flagSet, flagClr;
	logic irqN_r, irqN_nxt;

	// Measurement, detector, state and sequencer
	logic measBusy_r, measBusy_nxt, measStart, measDone;
	logic [CNT_W-1:0] measCnt_r, measCnt_nxt;
	logic [1:0] measPhase_r, measPhase_nxt;
	logic [LOAD_W-1:0] result_r, result_nxt;
	logic [DET_CNT_W-1:0] period_r, period_nxt;
	logic [2:0] good_r, good_nxt;
	logic extPresent_r, extPresent_nxt, extSel_r, extSel_nxt;
	logic detEn, periodOk, syncEvt;
	logic [4:0] freqMhz;
	logic [19:0] fp;
	mpb_state_t state_r, state_nxt;
	logic [CNT_W-1:0] bootCnt_r, bootCnt_nxt;
	logic noSyncEvt;
	logic regOut_r, regOut_nxt, seqBusy_r, seqBusy_nxt;
	logic seqTarget_r, seqTarget_nxt;
	logic [3:0] step_r, step_nxt;
	logic [CNT_W-1:0] unit_r, unit_nxt, unitLoad;
	logic selRise, selFall;

	assign addrTaken = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign wrStrobe = wrPend_r;

	always_comb
	begin
		wrPend_nxt = addrTaken && hwrite;
		rdWait_nxt = addrTaken && !hwrite;
		addr_nxt = addrTaken ? haddr[7:0] : addr_r;
		hrdata_nxt = rdWait_r ? readMux : hrdata_r;
	end

	always_comb
	begin
		readMux = '0;
		case (addr_r)
			OFF_MASTER_CTRL: readMux[4:0] = ctrl_r;
			OFF_SLAVE1_CTRL: readMux[DISCHARGE_BIT] = slaveDis_r[0];
			OFF_SLAVE2_CTRL: readMux[DISCHARGE_BIT] = slaveDis_r[1];
			OFF_SLAVE3_CTRL: readMux[DISCHARGE_BIT] = slaveDis_r[2];
			OFF_MASTER_DELAY: readMux[7:0] = delay_r;
			OFF_CONFIG: readMux[2:0] = cfg_r;
			OFF_CLOCK: readMux[6:0] = clkCfg_r;
			OFF_LOAD_SEL: readMux[1:0] = loadSel_r;
			OFF_LOAD_LO: readMux[LOAD_LO_W-1:0] = result_r[LOAD_LO_W-1:0];
			OFF_LOAD_HI:
				readMux[LOAD_W-LOAD_LO_W-1:0] =
					result_r[LOAD_W-1:LOAD_LO_W];
			OFF_FLAGS: readMux[6:0] = flags_r;
			OFF_MASKS: readMux[6:0] = masks_r;
			OFF_STATUS: readMux[5:0] = {ditherActive, extSel_r, extPresent_r,
				regOut_r, state_r};
			default: readMux = '0;
		endcase
	end

	// Register writes; slave delay registers decode to nothing
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		slaveDis_nxt = slaveDis_r;
		delay_nxt = delay_r;
		cfg_nxt = cfg_r;
		clkCfg_nxt = clkCfg_r;
		loadSel_nxt = loadSel_r;
		masks_nxt = masks_r;
		flagClr = '0;
		measStart = 1'b0;
		if (wrStrobe)
		begin
			case (addr_r)
				OFF_MASTER_CTRL: ctrl_nxt = hwdata[4:0];
				OFF_SLAVE1_CTRL: slaveDis_nxt[0] = hwdata[DISCHARGE_BIT];
				OFF_SLAVE2_CTRL: slaveDis_nxt[1] = hwdata[DISCHARGE_BIT];
				OFF_SLAVE3_CTRL: slaveDis_nxt[2] = hwdata[DISCHARGE_BIT];
				OFF_MASTER_DELAY: delay_nxt = hwdata[7:0];
				OFF_CONFIG: cfg_nxt = hwdata[2:0];
				OFF_CLOCK: clkCfg_nxt = hwdata[6:0];
				OFF_LOAD_SEL:
				begin
					loadSel_nxt = hwdata[1:0];
					measStart = 1'b1;
				end
				OFF_FLAGS: flagClr = hwdata[6:0];
				OFF_MASKS: masks_nxt = hwdata[6:0];
				default: ;
			endcase
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_comb
	begin
		flagSet = '0;
		flagSet.loadReady = measDone;
		flagSet.syncClk = syncEvt;
		flagSet.noSync = noSyncEvt;
		flagSet.curLimit = phaseCurrentLimit;
		flags_nxt = (flags_r & ~flagClr) | flagSet;
		irqN_nxt = ~|(flags_r & ~masks_r);
	end

	// Load-current measurement; a new write restarts a running one
	always_comb
	begin
		measBusy_nxt = measBusy_r;
		measCnt_nxt = measCnt_r;
		measPhase_nxt = measPhase_r;
		result_nxt = result_r;
		measDone = 1'b0;
		if (measStart)
		begin
			measBusy_nxt = 1'b1;
			measCnt_nxt = MEAS_LOAD;
			measPhase_nxt = hwdata[1:0];
		end
		else if (measBusy_r)
		begin
			if (measCnt_r == '0)
			begin
				measBusy_nxt = 1'b0;
				// Code is already current over 20 mA, saturating at 1023
				result_nxt = phaseCurrent[measPhase_r];
				measDone = 1'b1;
			end
			else
			begin
				measCnt_nxt = measCnt_r - 1'b1;
			end
		end
	end

	// External clock detector: count sys_clk cycles per sync period.
	// Above about 20 MHz the sampling jitter eats into the +10 % margin.
	assign freqMhz = (clkCfg_r.syncFreq > FREQ_MAX_CODE) ?
		FREQ_MAX_CODE + 5'h01 : clkCfg_r.syncFreq + 5'h01;
	assign fp = 20'(freqMhz) * 20'(period_r);
	assign periodOk = (DET_LO_NUM * fp <= DET_REF) &&
		(DET_HI_NUM * fp >= DET_REF);
	assign detEn = (clkCfg_r.mode == CLK_AUTO) ||
		((clkCfg_r.mode == CLK_ACTIVE_ONLY) && (state_r == ST_ACTIVE));

	always_comb
	begin
		period_nxt = period_r;
		good_nxt = good_r;
		extPresent_nxt = extPresent_r;
		if (pinRise[3])
		begin
			period_nxt = 8'h01;
			if (periodOk && period_r != DET_CNT_MAX)
			begin
				if (good_r != DET_GOOD_PERIODS)
					good_nxt = good_r + 3'h1;
				else
					extPresent_nxt = 1'b1;
			end
			else
			begin
				good_nxt = '0;
				extPresent_nxt = 1'b0;
			end
		end
		else if (period_r != DET_CNT_MAX)
		begin
			period_nxt = period_r + 8'h01;
		end
		else
		begin
			good_nxt = '0;
			extPresent_nxt = 1'b0;
		end
		syncEvt = detEn && (extPresent_nxt != extPresent_r);
		// Mux moves only while the sync clock sits low, so neither source
		// is cut mid-pulse
		extSel_nxt = pinLevel[3] ? extSel_r : (detEn && extPresent_r);
	end

	// Device state: boot load, then STANDBY; ACTIVE while output is on
	always_comb
	begin
		state_nxt = state_r;
		bootCnt_nxt = bootCnt_r;
		noSyncEvt = 1'b0;
		unique case (state_r)
			ST_BOOT:
				if (bootCnt_r == '0)
				begin
					state_nxt = ST_STANDBY;
					noSyncEvt = (clkCfg_r.mode == CLK_AUTO) && !extPresent_r;
				end
				else
					bootCnt_nxt = bootCnt_r - 1'b1;
			ST_STANDBY:
				if (regOut_r)
				begin
					state_nxt = ST_ACTIVE;
					noSyncEvt = (clkCfg_r.mode == CLK_ACTIVE_ONLY) &&
						!extPresent_r;
				end
			ST_ACTIVE:
				if (!regOut_r)
					state_nxt = ST_STANDBY;
			default: state_nxt = ST_BOOT;
		endcase
	end

	// Regulator enable sequencer
	always_comb
	begin
		unique case ({cfg_r.halfDelay, cfg_r.doubleDelay})
			2'b10: unitLoad = STEP_A;
			2'b11: unitLoad = STEP_B;
			2'b00: unitLoad = STEP_C;
			2'b01: unitLoad = STEP_D;
		endcase
		selRise = 1'b0;
		selFall = 1'b0;
		if (ctrl_r.pinChoice != 2'h3)
		begin
			selRise = pinRise[ctrl_r.pinChoice];
			selFall = pinFall[ctrl_r.pinChoice];
		end
	end

	always_comb
	begin
		regOut_nxt = regOut_r;
		seqBusy_nxt = seqBusy_r;
		seqTarget_nxt = seqTarget_r;
		step_nxt = step_r;
		unit_nxt = unit_r;
		if (state_r == ST_BOOT)
		begin
			regOut_nxt = 1'b0;
			seqBusy_nxt = 1'b0;
		end
		else if (!ctrl_r.regOn)
		begin
			regOut_nxt = 1'b0;
			seqBusy_nxt = 1'b0;
		end
		else if (!ctrl_r.pinCtrl)
		begin
			regOut_nxt = 1'b1;
			seqBusy_nxt = 1'b0;
		end
		else if (selRise || selFall)
		begin
			seqTarget_nxt = selRise;
			step_nxt = selRise ? delay_r.turnOn : delay_r.turnOff;
			unit_nxt = unitLoad;
			if (step_nxt == 4'h0)
			begin
				regOut_nxt = selRise;
				seqBusy_nxt = 1'b0;
			end
			else
				seqBusy_nxt = 1'b1;
		end
		else if (seqBusy_r)
		begin
			if (unit_r != '0)
				unit_nxt = unit_r - 1'b1;
			else if (step_r == 4'h1)
			begin
				regOut_nxt = seqTarget_r;
				seqBusy_nxt = 1'b0;
			end
			else
			begin
				step_nxt = step_r - 4'h1;
				unit_nxt = unitLoad;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wrPend_r <= 1'b0;
			rdWait_r <= 1'b0;
			addr_r <= '0;
			hrdata_r <= '0;
			ctrl_r <= CTRL_RST;
			slaveDis_r <= '0;
			delay_r <= DELAY_RST;
			cfg_r <= CFG_RST;
			clkCfg_r <= CLKCFG_RST;
			loadSel_r <= '0;
			flags_r <= FLAGS_RST;
			masks_r <= FLAGS_RST;
			irqN_r <= 1'b1;
			measBusy_r <= 1'b0;
			measCnt_r <= '0;
			measPhase_r <= '0;
			result_r <= '0;
			period_r <= DET_CNT_MAX;
			good_r <= '0;
			extPresent_r <= 1'b0;
			extSel_r <= 1'b0;
			state_r <= ST_BOOT;
			bootCnt_r <= BOOT_LOAD;
			regOut_r <= 1'b0;
			seqBusy_r <= 1'b0;
			seqTarget_r <= 1'b0;
			step_r <= '0;
			unit_r <= '0;
		end
		else
		begin
			wrPend_r <= wrPend_nxt;
			rdWait_r <= rdWait_nxt;
			addr_r <= addr_nxt;
			hrdata_r <= hrdata_nxt;
			ctrl_r <= ctrl_nxt;
			slaveDis_r <= slaveDis_nxt;
			delay_r <= delay_nxt;
			cfg_r <= cfg_nxt;
			clkCfg_r <= clkCfg_nxt;
			loadSel_r <= loadSel_nxt;
			flags_r <= flags_nxt;
			masks_r <= masks_nxt;
			irqN_r <= irqN_nxt;
			measBusy_r <= measBusy_nxt;
			measCnt_r <= measCnt_nxt;
			measPhase_r <= measPhase_nxt;
			result_r <= result_nxt;
			period_r <= period_nxt;
			good_r <= good_nxt;
			extPresent_r <= extPresent_nxt;
			extSel_r <= extSel_nxt;
			state_r <= state_nxt;
			bootCnt_r <= bootCnt_nxt;
			regOut_r <= regOut_nxt;
			seqBusy_r <= seqBusy_nxt;
			seqTarget_r <= seqTarget_nxt;
			step_r <= step_nxt;
			unit_r <= unit_nxt;
		end
	end

	// Read waits one cycle so the data flop sees any write just committed
	assign hreadyout = !rdWait_r;
	assign hrdata = hrdata_r;
	assign hresp = HRESP_OKAY;
	assign phaseEnable = {4{regOut_r}};
	assign outputDischargeEnable = {slaveDis_r, ctrl_r.discharge};
	assign useExternalClock = extSel_r;
	assign detectorEnable = detEn;
	assign ditherActive = cfg_r.dither && (clkCfg_r.mode == CLK_RC);
	assign irqOutN = irqN_r;

endmodule : mpb_control

// ===== mpb_control_properties.sv
/*
 * Port checker for mpb_control, bound into every instance.
 * Assumes single-word AHB-Lite transfers.
 */
`timescale 1ns/1ps
module mpb_control_props #(
	parameter int MEAS_CYC = 20,
	parameter int BOOT_CYC = 50
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [3:0] phaseEnable,
	input wire logic [3:0] outputDischargeEnable,
	input wire logic useExternalClock,
	input wire logic detectorEnable,
	input wire logic ditherActive,
	input wire logic irqOutN
);
	import mpb_pkg::*;
	localparam int MEAS_MAX = MEAS_CYC + 8;
	localparam int BOOT_MAX = BOOT_CYC + 8;
	logic [7:0] addr_r;
	logic wrPend_r;
	logic [1:0] mode_r;
	logic [6:0] mask_r;
	logic dis_r;
	int boot_r;
	logic take;
	logic wr;
	assign take = hsel && hready && htrans == HTRANS_NONSEQ;
	assign wr = wrPend_r && hreadyout;
	// Shadows of written fields, so outputs can be tied to their cause
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			addr_r <= '0;
			wrPend_r <= 1'b0;
			mode_r <= '0;
			mask_r <= '0;
			dis_r <= 1'b0;
			boot_r <= 0;
		end
		else
		begin
			wrPend_r <= take && hwrite;
			if (take)
				addr_r <= haddr[7:0];
			if (boot_r < BOOT_MAX)
				boot_r <= boot_r + 1;
			if (wr && addr_r == OFF_CLOCK)
				mode_r <= hwdata[1:0];
			if (wr && addr_r == OFF_MASKS)
				mask_r <= hwdata[6:0];
			if (wr && addr_r == OFF_SLAVE2_CTRL)
				dis_r <= hwdata[DISCHARGE_BIT];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_resp_okay: assert property (hresp == HRESP_OKAY)
		else $error("response not OKAY");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read data phase length wrong");
	a_phases_equal: assert property ($countones(phaseEnable) inside {0, 4})
		else $error("phases disagree");
	a_slave_discharge: assert property (
		wr && addr_r == OFF_SLAVE2_CTRL |-> ##2 outputDischargeEnable[2] == dis_r)
		else $error("slave discharge not applied");
	a_reg_off: assert property (
		wr && addr_r == OFF_MASTER_CTRL && !hwdata[0] |-> ##2 phaseEnable == 4'h0)
		else $error("register disable not immediate");
	a_reg_on: assert property (wr && addr_r == OFF_MASTER_CTRL
		&& hwdata[1:0] == 2'h1 && boot_r == BOOT_MAX |-> ##2 phaseEnable == 4'hF)
		else $error("register enable not immediate");
	a_detector_mode: assert property (
		mode_r == CLK_RC || mode_r == CLK_RSVD |-> !detectorEnable)
		else $error("detector on in RC mode");
	a_dither_rc: assert property (ditherActive |-> mode_r == CLK_RC)
		else $error("dither outside RC mode");
	a_ready_irq: assert property (wr && addr_r == OFF_LOAD_SEL && !mask_r[0]
		|-> ##[MEAS_CYC:MEAS_MAX] !irqOutN)
		else $error("measurement interrupt missing");
	a_mask_quiet: assert property ((mask_r == 7'h7F)[*4] |-> irqOutN)
		else $error("interrupt while all masked");
	c_irq: cover property (!irqOutN);
	c_ext: cover property (useExternalClock);
	c_on: cover property (phaseEnable == 4'hF);
endmodule : mpb_control_props

bind mpb_control mpb_control_props #(.MEAS_CYC(MEAS_CYC), .BOOT_CYC(BOOT_CYC))
	i_mpb_control_props (.sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hreadyout, .hresp, .phaseEnable, .outputDischargeEnable,
	.useExternalClock, .detectorEnable, .ditherActive, .irqOutN);

// ===== mpb_stage_model.sv
/*
 * Power stage and sync source model: fixed phase currents, 80 ns clock.
 * Assumes the bench gates the clock with syncOn and pulses limReq.
 */
`timescale 1ns/1ps
module mpb_stage_model #(
	parameter logic [39:0] CUR = '0
) (
	input wire logic syncOn,
	input wire logic [3:0] limReq,
	output logic syncClk,
	output logic [3:0][mpb_pkg::LOAD_W-1:0] cur,
	output logic [3:0] lim
);
	import mpb_pkg::*;
	assign cur = CUR;
	assign lim = limReq;
	// Offset keeps the sync edges off the system clock edges
	initial
	begin
		syncClk = 1'b0;
		#3;
		forever #40 syncClk = syncOn ? !syncClk : 1'b0;
	end
endmodule : mpb_stage_model

// ===== test_multiphase_buck_control.sv
/*
 * Self-checking bench of mpb_control with a power stage model.
 * Assumes shortened boot, measurement and delay-step counts.
 */
`timescale 1ns/1ps
module test_multiphase_buck_control;
	import mpb_pkg::*;
	localparam int MEAS = 20;
	localparam int BOOT = 50;
	localparam int STEP [4] = '{4, 8, 10, 20};
	// Config {half, double} codes in the order of STEP
	localparam logic [31:0] UNIT [4] = '{32'h2, 32'h3, 32'h0, 32'h1};
	localparam logic [39:0] CUR = {10'h201, 10'h0AA, 10'h155, 10'h3FF};
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic hreadyout;
	logic hresp;
	logic [2:0] pin = 3'h0;
	logic syncOn = 1'b0;
	logic syncClk;
	logic [3:0][LOAD_W-1:0] cur;
	logic [3:0] lim;
	logic [3:0] limReq = 4'h0;
	logic [3:0] phEn;
	logic [3:0] dis;
	logic useExt;
	logic detEn;
	logic dith;
	logic irqN;
	int errTotal = 0;
	int checksDone = 0;
	int cycles = 0;

	mpb_control #(.MEAS_CYC(MEAS), .BOOT_CYC(BOOT), .STEP_A_CYC(STEP[0]),
		.STEP_B_CYC(STEP[1]), .STEP_C_CYC(STEP[2]), .STEP_D_CYC(STEP[3]))
	i_mpb_control (.sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
		.enablePinOne(pin[0]), .enablePinTwo(pin[1]), .enablePinThree(pin[2]),
		.externalSyncInput(syncClk), .phaseCurrent(cur),
		.phaseCurrentLimit(lim), .phaseEnable(phEn),
		.outputDischargeEnable(dis), .useExternalClock(useExt),
		.detectorEnable(detEn), .ditherActive(dith), .irqOutN(irqN));
	mpb_stage_model #(.CUR(CUR)) i_mpb_stage_model (.syncOn, .limReq,
		.syncClk, .cur, .lim);

	always #4 sys_clk = !sys_clk;

	task automatic testDone;
		$display("checks %0d errors %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : testDone

	// Hang guard: the whole run needs a few thousand cycles
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errTotal++;
			testDone();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			errTotal++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc

	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		htrans <= HTRANS_NONSEQ;
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : xfer

	task automatic doReset;
		rstn <= 1'b0;
		pin <= 3'h0;
		syncOn <= 1'b0;
		cyc(4);
		rstn <= 1'b1;
		cyc(BOOT + 10);
	endtask : doReset

	task automatic tRegs;
		chk({phEn, dis, useExt, irqN}, 10'h1);
		for (int a = 0; a <= 8'h34; a += 4)
		begin
			xfer(1'b0, a[7:0], 32'h0);
			chk(rd, a == OFF_STATUS ? 32'h1 : 32'h0);
		end
		xfer(1'b1, OFF_SLAVE2_CTRL, 32'h1F);
		xfer(1'b0, OFF_SLAVE2_CTRL, 32'h0);
		chk(rd, 32'h10);
		chk({phEn, dis}, 8'h04);
		limReq <= 4'h4;
		cyc(1);
		limReq <= 4'h0;
		xfer(1'b0, OFF_FLAGS, 32'h0);
		chk(rd, 32'h20);
		chk(irqN, 1'b0);
		xfer(1'b1, OFF_FLAGS, 32'h20);
	endtask : tRegs

	task automatic tRegCtrl;
		xfer(1'b1, OFF_MASTER_DELAY, 32'hFF);
		xfer(1'b1, OFF_MASTER_CTRL, 32'h1);
		cyc(2);
		chk(phEn, 4'hF);
		xfer(1'b0, OFF_STATUS, 32'h0);
		chk(rd, 32'h6);
		pin <= 3'h7;
		xfer(1'b1, OFF_MASTER_CTRL, 32'h0);
		cyc(2);
		chk(phEn, 4'h0);
	endtask : tRegCtrl

	task automatic tPin(input int k);
		int p;
		int u;
		p = k % 3;
		u = STEP[k];
		doReset();
		xfer(1'b1, OFF_CONFIG, UNIT[k]);
		xfer(1'b1, OFF_MASTER_DELAY, 32'h12);
		xfer(1'b1, OFF_MASTER_CTRL, {28'h0, p[1:0], 2'h3});
		pin[(p + 1) % 3] <= 1'b1;
		cyc(20);
		chk(phEn, 4'h0);
		pin[p] <= 1'b1;
		cyc(2 * u - 1);
		chk(phEn, 4'h0);
		cyc(14);
		chk(phEn, 4'hF);
		pin[p] <= 1'b0;
		cyc(u - 1);
		chk(phEn, 4'hF);
		cyc(14);
		chk(phEn, 4'h0);
	endtask : tPin

	task automatic tMeas(input int s, input logic m);
		int n;
		xfer(1'b1, OFF_MASKS, m ? 32'h7F : 32'h0);
		xfer(1'b1, OFF_LOAD_SEL, s);
		n = 0;
		while (irqN === 1'b1 && n < MEAS + 12)
		begin
			cyc(1);
			n++;
		end
		chk(irqN, m);
		xfer(1'b0, OFF_LOAD_LO, 32'h0);
		chk(rd, CUR[s * 10 +: 8]);
		xfer(1'b0, OFF_LOAD_HI, 32'h0);
		chk(rd, CUR[s * 10 + 8 +: 2]);
		xfer(1'b0, OFF_FLAGS, 32'h0);
		chk(rd, 32'h1);
		xfer(1'b1, OFF_FLAGS, 32'h1);
		cyc(3);
		chk(irqN, 1'b1);
	endtask : tMeas

	task automatic tSync;
		doReset();
		xfer(1'b1, OFF_CONFIG, 32'h4);
		cyc(1);
		chk(dith, 1'b1);
		xfer(1'b1, OFF_CLOCK, 32'h32);
		syncOn <= 1'b1;
		cyc(150);
		chk({dith, detEn, useExt}, 3'h0);
		xfer(1'b1, OFF_CLOCK, 32'h31);
		cyc(150);
		chk({detEn, useExt, irqN}, 3'h7);
		xfer(1'b1, OFF_CLOCK, 32'h05);
		cyc(150);
		chk({useExt, irqN}, 2'h0);
		xfer(1'b1, OFF_FLAGS, 32'h7F);
		xfer(1'b1, OFF_CLOCK, 32'h31);
		cyc(150);
		xfer(1'b0, OFF_FLAGS, 32'h0);
		chk(rd, 32'h2);
		chk(useExt, 1'b1);
		xfer(1'b1, OFF_FLAGS, 32'h7F);
		syncOn <= 1'b0;
		cyc(320);
		chk(useExt, 1'b0);
		xfer(1'b0, OFF_FLAGS, 32'h0);
		chk(rd, 32'h2);
		xfer(1'b1, OFF_FLAGS, 32'h7F);
		xfer(1'b1, OFF_CLOCK, 32'h32);
		xfer(1'b1, OFF_MASTER_CTRL, 32'h1);
		cyc(4);
		xfer(1'b0, OFF_FLAGS, 32'h0);
		chk(rd, 32'h4);
		chk(detEn, 1'b1);
	endtask : tSync

	initial
	begin
		doReset();
		tRegs();
		tRegCtrl();
		for (int k = 0; k < 4; k++)
			tPin(k);
		for (int s = 0; s < 4; s++)
			tMeas(s, s == 1);
		tSync();
		testDone();
	end
endmodule : test_multiphase_buck_control
